// [src/pmc_regs.sv]
// Vendor configuration registers and mode logic for the parallel and serial ports.
`include "pmc_consts.svh"
`default_nettype none

// Behaviour
// RULE1: Parallel mode field decodes seven port modes.
// RULE2: Bits six to three hold FIFO threshold.
// RULE3: Interrupt type ignored in printer, standard modes.
// RULE4: Type one pulses interrupt low, then releases.
// RULE5: Type zero follows acknowledge in EPP-like modes.
// RULE6: Type zero gives level interrupt in FIFO modes.
// RULE7: Multiplex code 00 keeps pins purely parallel.
// RULE8: Code 01 puts drive 1 on parallel pins.
// RULE9: Code 10 puts drives 0, 1 there.
// RULE10: Software writes zero to reserved multiplex bits.
// RULE11: Serial bit zero enables MIDI, reset off.
// RULE12: Serial bit one enables high speed.
// RULE13: First serial bit seven selects interrupt sharing.
// RULE14: Software assigns one line before enabling sharing.
// RULE15: Shared mode asserts both lines on either.
// RULE16: Infrared bits zero, one set polarities.
// RULE17: Infrared bit two selects half duplex.
// RULE18: Infrared bits five to three select mode.
// RULE19: Infrared bit six selects alternate pins.
// RULE20: Timeout register counts 100 us steps, resets three.
// RULE21: Half duplex blanks opposite direction plus timeout.
// RULE22: Software writes zero to reserved serial bits.
// RULE23: Registers reset only on hard reset.
// RULE24: Indices decode within selected logical device.
module pmc_regs #(
  parameter int unsigned HDX_STEP_CYCLES =
    (`PMC_HDX_STEP_NS + `PMC_CLK_PERIOD_NS - 1) / `PMC_CLK_PERIOD_NS
) (
  input  wire logic               clk_i,
  input  wire logic               reset_i,
  input  wire logic               soft_reset_i,
  input  wire logic               ce_i,
  input  wire logic [7:0]         ldn_i,
  input  wire logic [7:0]         reg_addr_i,
  input  wire logic [7:0]         reg_wdata_i,
  input  wire logic               reg_wr_i,
  input  wire logic               reg_rd_i,
  output logic      [7:0]         reg_rdata_o,
  output pmc_pkg::pmc_pp_mode_t   pp_mode_o,
  output logic                    epp_enable_o,
  output logic                    epp_v17_o,
  output logic                    ecp_enable_o,
  output logic      [3:0]         ecp_fifo_threshold_o,
  input  wire pmc_pkg::pmc_ecr_mode_t ecr_mode_i,
  input  wire logic               printer_acknowledge_input_n_i,
  input  wire logic               ecp_irq_level_i,
  input  wire logic               pp_irq_enable_i,
  output logic                    pp_irq_o,
  output logic                    pp_irq_oe_o,
  output logic      [1:0]         parallel_floppy_mux_field_o,
  output logic                    one_drive_on_parallel_pins_o,
  output logic                    two_drives_on_parallel_pins_o,
  output logic      [3:0]         drive_on_parallel_o,
  output logic                    serial1_midi_o,
  output logic                    serial1_high_speed_o,
  output logic                    serial2_midi_o,
  output logic                    serial2_high_speed_o,
  input  wire logic               serial1_irq_i,
  input  wire logic               serial2_irq_i,
  output logic                    serial1_irq_o,
  output logic                    serial2_irq_o,
  output logic                    ir_rx_active_low_o,
  output logic                    ir_tx_active_low_o,
  output logic                    ir_half_duplex_o,
  output pmc_pkg::pmc_ir_mode_t   ir_mode_o,
  output logic                    ir_alternate_pins_o,
  input  wire logic               ir_tx_data_i,
  output logic                    ir_rx_data_o,
  input  wire logic               serial2_receive_pin_i,
  input  wire logic               alternate_infrared_receive_pin_i,
  output logic                    serial2_transmit_pin_o,
  output logic                    alternate_infrared_transmit_pin_o
);
  import pmc_pkg::*;

  localparam int unsigned PULSE_CYCLES =
    (`PMC_IRQ_PULSE_NS + `PMC_CLK_PERIOD_NS - 1) / `PMC_CLK_PERIOD_NS;

  // ==========================================================================
  // Register decode
  // ==========================================================================
  function automatic logic reg_hit(input logic [7:0] ldn, input logic [7:0] idx,
                                   input logic [7:0] want_ldn, input logic [7:0] want_idx);
    reg_hit = (ldn == want_ldn) && (idx == want_idx);
  endfunction : reg_hit

  wire logic hit_pp_mode = reg_hit(ldn_i, reg_addr_i, `PMC_LDN_PARALLEL, `PMC_IDX_F0); // [RULE24]
  wire logic hit_pp_mux  = reg_hit(ldn_i, reg_addr_i, `PMC_LDN_PARALLEL, `PMC_IDX_F1); // [RULE24]
  wire logic hit_s1_mode = reg_hit(ldn_i, reg_addr_i, `PMC_LDN_SERIAL1, `PMC_IDX_F0);  // [RULE24]
  wire logic hit_s2_mode = reg_hit(ldn_i, reg_addr_i, `PMC_LDN_SERIAL2, `PMC_IDX_F0);  // [RULE24]
  wire logic hit_ir_opt  = reg_hit(ldn_i, reg_addr_i, `PMC_LDN_SERIAL2, `PMC_IDX_F1);  // [RULE24]
  wire logic hit_ir_tmo  = reg_hit(ldn_i, reg_addr_i, `PMC_LDN_SERIAL2, `PMC_IDX_F2);  // [RULE24]
  wire logic wr_en       = ce_i && reg_wr_i;

  // ==========================================================================
  // Registers
  // ==========================================================================
  logic [7:0] pp_mode_r;
  logic [1:0] pp_mux_r;
  logic [1:0] s1_mode_r;
  logic       s1_share_r;
  logic [1:0] s2_mode_r;
  logic [6:0] ir_opt_r;
  logic [7:0] ir_tmo_r;
  logic [7:0] rdata_nxt;

  // The soft reset input is deliberately not used by any register here.
  wire logic soft_reset_unused = soft_reset_i; // [RULE23]

  always_ff @(posedge clk_i) begin
    if (reset_i) begin // [RULE23]
      pp_mode_r  <= `PMC_PP_MODE_RST; // [RULE1] [RULE2]
      pp_mux_r   <= `PMC_PP_MUX_RST; // [RULE7]
      s1_mode_r  <= 2'h0; // [RULE11] [RULE12]
      s1_share_r <= 1'b0;
      s2_mode_r  <= 2'h0; // [RULE11] [RULE12]
      ir_opt_r   <= `PMC_IR_OPT_RST; // [RULE16] [RULE17] [RULE18] [RULE19]
      ir_tmo_r   <= `PMC_IR_TMO_RST; // [RULE20]
    end else if (wr_en) begin
      if (hit_pp_mode) begin
        pp_mode_r <= reg_wdata_i;
      end
      if (hit_pp_mux) begin
        pp_mux_r <= reg_wdata_i[1:0]; // [RULE10]
      end
      if (hit_s1_mode) begin
        s1_mode_r  <= reg_wdata_i[`PMC_SER_HS_BIT:`PMC_SER_MIDI_BIT]; // [RULE22]
        s1_share_r <= reg_wdata_i[`PMC_SER_SHARE_BIT]; // [RULE13]
      end
      if (hit_s2_mode) begin
        s2_mode_r <= reg_wdata_i[`PMC_SER_HS_BIT:`PMC_SER_MIDI_BIT]; // [RULE22]
      end
      if (hit_ir_opt) begin
        ir_opt_r <= reg_wdata_i[6:0];
      end
      if (hit_ir_tmo) begin
        ir_tmo_r <= reg_wdata_i; // [RULE20]
      end
    end
  end

  // Read data stand only in the cycle after the read strobe; misses read zero.
  assign rdata_nxt = !reg_rd_i   ? 8'h00 :
                     hit_pp_mode ? pp_mode_r :
                     hit_pp_mux  ? {6'h00, pp_mux_r} :
                     hit_s1_mode ? {s1_share_r, 5'h00, s1_mode_r} :
                     hit_s2_mode ? {6'h00, s2_mode_r} :
                     hit_ir_opt  ? {1'b0, ir_opt_r} :
                     hit_ir_tmo  ? ir_tmo_r : 8'h00;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      reg_rdata_o <= 8'h00;
    end else if (ce_i) begin
      reg_rdata_o <= rdata_nxt;
    end
  end

  // ==========================================================================
  // Parallel port mode and floppy multiplexing
  // ==========================================================================
  wire pmc_pp_mode_t pp_mode = pmc_pp_mode_t'(pp_mode_r[`PMC_PP_MODE_MSB:`PMC_PP_MODE_LSB]);
  assign pp_mode_o            = pp_mode; // [RULE1]
  assign epp_enable_o         = (pp_mode == PMC_PP_EPP19) || (pp_mode == PMC_PP_EPP17) ||
                                (pp_mode == PMC_PP_ECP_E19) || (pp_mode == PMC_PP_ECP_E17); // [RULE1]
  assign epp_v17_o            = (pp_mode == PMC_PP_EPP17) || (pp_mode == PMC_PP_ECP_E17); // [RULE1]
  assign ecp_enable_o         = (pp_mode == PMC_PP_ECP) || (pp_mode == PMC_PP_ECP_E19) ||
                                (pp_mode == PMC_PP_ECP_E17); // [RULE1]
  assign ecp_fifo_threshold_o = pp_mode_r[`PMC_PP_THR_MSB:`PMC_PP_THR_LSB]; // [RULE2]

  assign parallel_floppy_mux_field_o   = pp_mux_r;
  assign one_drive_on_parallel_pins_o  = (pp_mux_r == 2'h1); // [RULE8]
  assign two_drives_on_parallel_pins_o = (pp_mux_r == 2'h2); // [RULE9]
  // Code 11 is treated as the plain parallel port, like code 00.
  assign drive_on_parallel_o = {2'h0, one_drive_on_parallel_pins_o | two_drives_on_parallel_pins_o,
                                two_drives_on_parallel_pins_o}; // [RULE7] [RULE8] [RULE9]

  // ==========================================================================
  // Parallel port interrupt
  // ==========================================================================
  wire logic basic_mode  = (pp_mode == PMC_PP_PRINTER) || (pp_mode == PMC_PP_SPP);
  wire logic pulse_type  = pp_mode_r[`PMC_PP_ITYPE_BIT] && !basic_mode; // [RULE3]
  wire logic ecr_fifo    = (ecr_mode_i == PMC_ECR_FIFO) || (ecr_mode_i == PMC_ECR_ECP) ||
                           (ecr_mode_i == PMC_ECR_TEST);
  wire logic level_src   = ecp_enable_o && ecr_fifo; // [RULE6]
  wire logic irq_src     = level_src ? ecp_irq_level_i : printer_acknowledge_input_n_i; // [RULE5]
  logic             irq_src_q;
  logic [7:0]       pulse_cnt_r;
  pmc_pulse_state_t pulse_st_r;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      irq_src_q   <= 1'b0;
      pulse_st_r  <= PMC_PULSE_IDLE;
      pulse_cnt_r <= 8'h00;
    end else if (ce_i) begin
      irq_src_q <= irq_src;
      unique case (pulse_st_r)
        PMC_PULSE_IDLE: begin
          if (pulse_type && irq_src && !irq_src_q) begin // [RULE4]
            pulse_st_r  <= PMC_PULSE_LOW;
            pulse_cnt_r <= 8'(PULSE_CYCLES - 1);
          end
        end
        PMC_PULSE_LOW: begin
          if (pulse_cnt_r == 8'h00) begin
            pulse_st_r <= PMC_PULSE_IDLE;
          end else begin
            pulse_cnt_r <= pulse_cnt_r - 8'h01;
          end
        end
      endcase
    end
  end

  assign pp_irq_o    = pulse_type ? 1'b0 : irq_src; // [RULE4] [RULE5] [RULE6]
  assign pp_irq_oe_o = pp_irq_enable_i &&
                       (pulse_type ? (pulse_st_r == PMC_PULSE_LOW) : 1'b1); // [RULE4]

  // ==========================================================================
  // Serial port modes and interrupt sharing
  // ==========================================================================
  assign serial1_midi_o       = s1_mode_r[`PMC_SER_MIDI_BIT]; // [RULE11]
  assign serial1_high_speed_o = s1_mode_r[`PMC_SER_HS_BIT]; // [RULE12]
  assign serial2_midi_o       = s2_mode_r[`PMC_SER_MIDI_BIT]; // [RULE11]
  assign serial2_high_speed_o = s2_mode_r[`PMC_SER_HS_BIT]; // [RULE12]
  wire logic any_serial_irq   = serial1_irq_i || serial2_irq_i;
  assign serial1_irq_o = s1_share_r ? any_serial_irq : serial1_irq_i; // [RULE13] [RULE15]
  assign serial2_irq_o = s1_share_r ? any_serial_irq : serial2_irq_i; // [RULE13] [RULE15]

  // ==========================================================================
  // Infrared options and half-duplex blanking
  // ==========================================================================
  assign ir_rx_active_low_o  = ir_opt_r[`PMC_IR_RXPOL_BIT]; // [RULE16]
  assign ir_tx_active_low_o  = ir_opt_r[`PMC_IR_TXPOL_BIT]; // [RULE16]
  assign ir_half_duplex_o    = ir_opt_r[`PMC_IR_HDX_BIT]; // [RULE17]
  assign ir_mode_o           = pmc_ir_mode_t'(ir_opt_r[`PMC_IR_MODE_MSB:`PMC_IR_MODE_LSB]); // [RULE18]
  assign ir_alternate_pins_o = ir_opt_r[`PMC_IR_LOC_BIT]; // [RULE19]

  wire logic ir_on     = (ir_mode_o == PMC_IR_IRDA) || (ir_mode_o == PMC_IR_ASK); // [RULE18]
  wire logic rx_pin    = ir_alternate_pins_o ? alternate_infrared_receive_pin_i
                                             : serial2_receive_pin_i; // [RULE19]
  // An active pulse on the line is a space bit toward the UART.
  wire logic rx_pulse  = ir_on && (rx_pin ^ ir_rx_active_low_o); // [RULE16]
  wire logic tx_pulse  = ir_on && !ir_tx_data_i;
  wire logic [1:0] act = {rx_pulse, tx_pulse};
  logic      [1:0] hold;

  // Index 0 extends transmit activity, index 1 extends receive activity.
  for (genvar d = 0; d < 2; d++) begin : g_hold
    logic [7:0]  steps_r;
    logic [15:0] presc_r;
    always_ff @(posedge clk_i) begin
      if (reset_i) begin
        steps_r <= 8'h00;
        presc_r <= 16'h0000;
      end else if (ce_i) begin
        if (act[d]) begin
          steps_r <= ir_tmo_r; // [RULE21]
          presc_r <= 16'h0000;
        end else if (steps_r != 8'h00) begin
          if (presc_r == 16'(HDX_STEP_CYCLES - 1)) begin // [RULE20]
            presc_r <= 16'h0000;
            steps_r <= steps_r - 8'h01;
          end else begin
            presc_r <= presc_r + 16'h0001;
          end
        end
      end
    end
    assign hold[d] = act[d] || (steps_r != 8'h00); // [RULE21]
  end

  wire logic blank_rx = ir_half_duplex_o && hold[0]; // [RULE21]
  wire logic blank_tx = ir_half_duplex_o && hold[1]; // [RULE21]
  wire logic rx_data  = ir_on ? !(rx_pulse && !blank_rx) : rx_pin;
  wire logic tx_act   = tx_pulse && !blank_tx;
  wire logic tx_line  = ir_on ? (tx_act ^ ir_tx_active_low_o) : ir_tx_data_i; // [RULE16]
  wire logic tx_idle  = ir_on ? ir_tx_active_low_o : 1'b1;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ir_rx_data_o                      <= 1'b1;
      serial2_transmit_pin_o            <= 1'b1;
      alternate_infrared_transmit_pin_o <= 1'b1;
    end else if (ce_i) begin
      ir_rx_data_o                      <= rx_data;
      serial2_transmit_pin_o            <= ir_alternate_pins_o ? tx_idle : tx_line; // [RULE19]
      alternate_infrared_transmit_pin_o <= ir_alternate_pins_o ? tx_line : tx_idle; // [RULE19]
    end
  end

endmodule : pmc_regs
`default_nettype wire

// [src/pmc_consts.svh]
// Register offsets, field positions, reset values and timing figures of the port mode block.
`ifndef PMC_CONSTS_SVH
`define PMC_CONSTS_SVH

// ==========================================================================
// Logical device numbers and register indices
// ==========================================================================
`define PMC_LDN_PARALLEL     8'h03
`define PMC_LDN_SERIAL1      8'h04
`define PMC_LDN_SERIAL2      8'h05
`define PMC_IDX_F0           8'hf0
`define PMC_IDX_F1           8'hf1
`define PMC_IDX_F2           8'hf2

// ==========================================================================
// Reset values
// ==========================================================================
`define PMC_PP_MODE_RST      8'h3c
`define PMC_PP_MUX_RST       2'h0
`define PMC_SER_MODE_RST     8'h00
`define PMC_IR_OPT_RST       7'h02
`define PMC_IR_TMO_RST       8'h03

// ==========================================================================
// Field positions
// ==========================================================================
`define PMC_PP_MODE_LSB      0
`define PMC_PP_MODE_MSB      2
`define PMC_PP_THR_LSB       3
`define PMC_PP_THR_MSB       6
`define PMC_PP_ITYPE_BIT     7
`define PMC_SER_MIDI_BIT     0
`define PMC_SER_HS_BIT       1
`define PMC_SER_SHARE_BIT    7
`define PMC_IR_RXPOL_BIT     0
`define PMC_IR_TXPOL_BIT     1
`define PMC_IR_HDX_BIT       2
`define PMC_IR_MODE_LSB      3
`define PMC_IR_MODE_MSB      5
`define PMC_IR_LOC_BIT       6

// ==========================================================================
// Timing
// ==========================================================================
`define PMC_CLK_PERIOD_NS    4
`define PMC_HDX_STEP_NS      100000
`define PMC_IRQ_PULSE_NS     100

`endif

// [src/pmc_pkg.sv]
// Types shared by the port mode configuration block.
`default_nettype none
package pmc_pkg;

  // ==========================================================================
  // Encodings
  // ==========================================================================
  typedef enum logic [2:0] {
    PMC_PP_SPP      = 3'h0,
    PMC_PP_EPP19    = 3'h1,
    PMC_PP_ECP      = 3'h2,
    PMC_PP_ECP_E19  = 3'h3,
    PMC_PP_PRINTER  = 3'h4,
    PMC_PP_EPP17    = 3'h5,
    PMC_PP_RSVD     = 3'h6,
    PMC_PP_ECP_E17  = 3'h7
  } pmc_pp_mode_t;

  typedef enum logic [2:0] {
    PMC_ECR_PRINTER = 3'h0,
    PMC_ECR_SPP     = 3'h1,
    PMC_ECR_FIFO    = 3'h2,
    PMC_ECR_ECP     = 3'h3,
    PMC_ECR_EPP     = 3'h4,
    PMC_ECR_RSVD    = 3'h5,
    PMC_ECR_TEST    = 3'h6,
    PMC_ECR_CONFIG  = 3'h7
  } pmc_ecr_mode_t;

  typedef enum logic [2:0] {
    PMC_IR_STANDARD = 3'h0,
    PMC_IR_IRDA     = 3'h1,
    PMC_IR_ASK      = 3'h2
  } pmc_ir_mode_t;

  typedef enum logic {
    PMC_PULSE_IDLE  = 1'b0,
    PMC_PULSE_LOW   = 1'b1
  } pmc_pulse_state_t;

endpackage : pmc_pkg
`default_nettype wire

// [bench/pmc_regs_sva.sv]
// Concurrent checks on the ports of the port mode configuration registers.
`default_nettype none
module pmc_regs_sva (
  input wire logic                  clk_i,
  input wire logic                  reset_i,
  input wire logic                  soft_reset_i,
  input wire logic                  ce_i,
  input wire logic [7:0]            ldn_i,
  input wire logic [7:0]            reg_addr_i,
  input wire logic                  reg_wr_i,
  input wire logic                  reg_rd_i,
  input wire logic [7:0]            reg_rdata_o,
  input wire pmc_pkg::pmc_pp_mode_t pp_mode_o,
  input wire logic [3:0]            ecp_fifo_threshold_o,
  input wire logic [1:0]            parallel_floppy_mux_field_o,
  input wire logic [3:0]            drive_on_parallel_o,
  input wire logic                  serial1_irq_i,
  input wire logic                  serial2_irq_i,
  input wire logic                  serial2_irq_o
);
  import pmc_pkg::*;
  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  wire logic rd_pp = reg_rd_i && ce_i && ldn_i == 8'h03;

  read_idle_zero_a: assert property ($past(ce_i) && !$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
    else $error("read data not zero outside read cycle");
  mode_read_back_a: assert property (rd_pp && reg_addr_i == 8'hf0 |=>
    reg_rdata_o[2:0] == $past(pp_mode_o)) else $error("mode field read mismatch");
  thr_read_back_a: assert property (rd_pp && reg_addr_i == 8'hf0 |=>
    reg_rdata_o[6:3] == $past(ecp_fifo_threshold_o)) else $error("threshold read mismatch");
  mux_read_back_a: assert property (rd_pp && reg_addr_i == 8'hf1 |=>
    reg_rdata_o == {6'h00, $past(parallel_floppy_mux_field_o)}) else $error("mux read mismatch");
  unmapped_read_a: assert property (reg_rd_i && ce_i && ldn_i == 8'h07 |=>
    reg_rdata_o == 8'h00) else $error("unmapped read not zero");
  mux_drive_decode_a: assert property (drive_on_parallel_o ==
    (parallel_floppy_mux_field_o == 2'h1 ? 4'h2 : parallel_floppy_mux_field_o == 2'h2 ? 4'h3 : 4'h0))
    else $error("drive routing does not match mux field");
  irq_share_a: assert property (serial2_irq_o && !serial2_irq_i |-> serial1_irq_i)
    else $error("second serial interrupt without a source");
  soft_reset_keep_a: assert property (soft_reset_i && !reg_wr_i |=>
    $stable(pp_mode_o) && $stable(ecp_fifo_threshold_o)) else $error("soft reset changed mode");
endmodule : pmc_regs_sva

bind pmc_regs pmc_regs_sva u_sva (.clk_i(clk_i), .reset_i(reset_i), .soft_reset_i(soft_reset_i),
  .ce_i(ce_i), .ldn_i(ldn_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .pp_mode_o(pp_mode_o), .ecp_fifo_threshold_o(ecp_fifo_threshold_o),
  .parallel_floppy_mux_field_o(parallel_floppy_mux_field_o),
  .drive_on_parallel_o(drive_on_parallel_o), .serial1_irq_i(serial1_irq_i),
  .serial2_irq_i(serial2_irq_i), .serial2_irq_o(serial2_irq_o));
`default_nettype wire

// [bench/testbench.sv]
// Self-checking testbench for the port mode configuration registers.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import pmc_pkg::*;
  // ==========================================================================
  // Stimulus and observed signals
  // ==========================================================================
  logic clk_i = 0, reset_i = 1, soft_reset_i = 0, ce_i = 1, reg_wr_i = 0, reg_rd_i = 0;
  logic [7:0] ldn_i = 0, reg_addr_i = 0, reg_wdata_i = 0, reg_rdata_o;
  pmc_ecr_mode_t ecr_mode_i = PMC_ECR_SPP;
  logic printer_acknowledge_input_n_i = 1, ecp_irq_level_i = 0, pp_irq_enable_i = 1;
  logic serial1_irq_i = 0, serial2_irq_i = 0, ir_tx_data_i = 1, serial2_receive_pin_i = 1;
  logic alternate_infrared_receive_pin_i = 1;
  pmc_pp_mode_t pp_mode_o;
  pmc_ir_mode_t ir_mode_o;
  logic [3:0] ecp_fifo_threshold_o, drive_on_parallel_o;
  logic [1:0] parallel_floppy_mux_field_o;
  logic epp_enable_o, epp_v17_o, ecp_enable_o, pp_irq_o, pp_irq_oe_o;
  logic one_drive_on_parallel_pins_o, two_drives_on_parallel_pins_o;
  logic serial1_midi_o, serial1_high_speed_o, serial2_midi_o, serial2_high_speed_o;
  logic serial1_irq_o, serial2_irq_o, ir_rx_active_low_o, ir_tx_active_low_o, ir_half_duplex_o;
  logic ir_alternate_pins_o, ir_rx_data_o, serial2_transmit_pin_o;
  logic alternate_infrared_transmit_pin_o;
  logic [5:0] mux_exp [4] = '{6'h00, 6'h22, 6'h13, 6'h00};
  int fails = 0, compares = 0;

  always #2 clk_i = ~clk_i;

  pmc_regs #(.HDX_STEP_CYCLES(4)) dut (.clk_i, .reset_i, .soft_reset_i, .ce_i, .ldn_i,
    .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .pp_mode_o, .epp_enable_o,
    .epp_v17_o, .ecp_enable_o, .ecp_fifo_threshold_o, .ecr_mode_i,
    .printer_acknowledge_input_n_i, .ecp_irq_level_i, .pp_irq_enable_i, .pp_irq_o, .pp_irq_oe_o,
    .parallel_floppy_mux_field_o, .one_drive_on_parallel_pins_o, .two_drives_on_parallel_pins_o,
    .drive_on_parallel_o, .serial1_midi_o, .serial1_high_speed_o, .serial2_midi_o,
    .serial2_high_speed_o, .serial1_irq_i, .serial2_irq_i, .serial1_irq_o, .serial2_irq_o,
    .ir_rx_active_low_o, .ir_tx_active_low_o, .ir_half_duplex_o, .ir_mode_o, .ir_alternate_pins_o,
    .ir_tx_data_i, .ir_rx_data_o, .serial2_receive_pin_i, .alternate_infrared_receive_pin_i,
    .serial2_transmit_pin_o, .alternate_infrared_transmit_pin_o);

  // ==========================================================================
  // Tasks
  // ==========================================================================
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic step;
    @(posedge clk_i);
    #1;
  endtask : step

  task automatic wr(input logic [7:0] l, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_wr_i <= 1'b1;
    ldn_i <= l;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] l, input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    reg_rd_i <= 1'b1;
    ldn_i <= l;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1;
    chk(reg_rdata_o, exp);
  endtask : rd

  task automatic results;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : results

  initial begin
    #20000;
    fails++;
    results();
  end

  // ==========================================================================
  // Tests
  // ==========================================================================
  initial begin
    int n;
    repeat (16) @(posedge clk_i);
    reset_i <= 1'b0;
    rd(8'h03, 8'hf0, 8'h3c);
    rd(8'h03, 8'hf1, 8'h00);
    rd(8'h04, 8'hf0, 8'h00);
    rd(8'h05, 8'hf0, 8'h00);
    rd(8'h05, 8'hf1, 8'h02);
    rd(8'h05, 8'hf2, 8'h03);
    chk({1'b0, ir_mode_o, ir_rx_active_low_o, ir_tx_active_low_o, ir_half_duplex_o,
         ir_alternate_pins_o}, 8'h04);
    $display("test reset values done");
    for (int m = 0; m < 8; m++) begin
      if (m != 6) begin
        wr(8'h03, 8'hf0, {1'b0, 4'h7, 3'(m)});
        chk({5'h0, pp_mode_o}, 8'(m));
        chk({5'h0, epp_enable_o, epp_v17_o, ecp_enable_o},
            {5'h0, m[0], m == 5 || m == 7, m == 2 || m == 3 || m == 7});
      end
    end
    wr(8'h03, 8'hf0, 8'h52);
    chk({4'h0, ecp_fifo_threshold_o}, 8'h0a);
    rd(8'h03, 8'hf0, 8'h52);
    for (int m = 0; m < 4; m++) begin
      wr(8'h03, 8'hf1, 8'(m));
      chk({2'h0, one_drive_on_parallel_pins_o, two_drives_on_parallel_pins_o,
           drive_on_parallel_o}, {2'h0, mux_exp[m]});
      rd(8'h03, 8'hf1, 8'(m));
    end
    $display("test parallel modes done");
    wr(8'h04, 8'hf0, 8'h83);
    wr(8'h05, 8'hf0, 8'h02);
    chk({4'h0, serial1_midi_o, serial1_high_speed_o, serial2_midi_o, serial2_high_speed_o},
        8'h0d);
    rd(8'h04, 8'hf0, 8'h83);
    rd(8'h05, 8'hf0, 8'h02);
    @(posedge clk_i) serial1_irq_i <= 1'b1;
    step();
    chk({6'h0, serial1_irq_o, serial2_irq_o}, 8'h03);
    wr(8'h04, 8'hf0, 8'h03);
    chk({6'h0, serial1_irq_o, serial2_irq_o}, 8'h02);
    @(posedge clk_i) serial1_irq_i <= 1'b0;
    $display("test serial done");
    wr(8'h05, 8'hf1, 8'h4d);
    chk({1'b0, ir_mode_o, ir_rx_active_low_o, ir_tx_active_low_o, ir_half_duplex_o,
         ir_alternate_pins_o}, 8'h1b);
    wr(8'h05, 8'hf1, 8'h10);
    chk({1'b0, ir_mode_o, ir_rx_active_low_o, ir_tx_active_low_o, ir_half_duplex_o,
         ir_alternate_pins_o}, 8'h20);
    wr(8'h05, 8'hf2, 8'h64);
    rd(8'h05, 8'hf2, 8'h64);
    wr(8'h05, 8'hf2, 8'h01);
    wr(8'h05, 8'hf1, 8'h0d);
    repeat (4) step();
    @(posedge clk_i) ir_tx_data_i <= 1'b0;
    step();
    chk({6'h0, serial2_transmit_pin_o, alternate_infrared_transmit_pin_o},
        8'h02);
    @(posedge clk_i) ir_tx_data_i <= 1'b1;
    serial2_receive_pin_i <= 1'b0;
    repeat (4) step();
    chk({7'h0, ir_rx_data_o}, 8'h01);
    step();
    chk({7'h0, ir_rx_data_o}, 8'h00);
    @(posedge clk_i) serial2_receive_pin_i <= 1'b1;
    $display("test infrared done");
    @(posedge clk_i) printer_acknowledge_input_n_i <= 1'b0;
    wr(8'h03, 8'hf0, 8'hba);
    @(posedge clk_i) printer_acknowledge_input_n_i <= 1'b1;
    n = 0;
    repeat (40) begin
      step();
      if (pp_irq_oe_o === 1'b1 && pp_irq_o === 1'b0) n++;
    end
    chk(8'(n), 8'h19);
    wr(8'h03, 8'hf0, 8'hbc);
    @(posedge clk_i) printer_acknowledge_input_n_i <= 1'b0;
    step();
    chk({6'h0, pp_irq_oe_o, pp_irq_o}, 8'h02);
    @(posedge clk_i) printer_acknowledge_input_n_i <= 1'b1;
    step();
    chk({6'h0, pp_irq_oe_o, pp_irq_o}, 8'h03);
    wr(8'h03, 8'hf0, 8'h3a);
    @(posedge clk_i) ecr_mode_i <= PMC_ECR_FIFO;
    ecp_irq_level_i <= 1'b1;
    step();
    chk({6'h0, pp_irq_oe_o, pp_irq_o}, 8'h03);
    @(posedge clk_i) ecp_irq_level_i <= 1'b0;
    step();
    chk({6'h0, pp_irq_oe_o, pp_irq_o}, 8'h02);
    $display("test parallel interrupt done");
    @(posedge clk_i) soft_reset_i <= 1'b1;
    step();
    @(posedge clk_i) soft_reset_i <= 1'b0;
    rd(8'h03, 8'hf0, 8'h3a);
    wr(8'h07, 8'hf0, 8'hff);
    rd(8'h07, 8'hf0, 8'h00);
    rd(8'h03, 8'hf2, 8'h00);
    @(posedge clk_i) reset_i <= 1'b1;
    step();
    @(posedge clk_i) reset_i <= 1'b0;
    rd(8'h03, 8'hf0, 8'h3c);
    rd(8'h05, 8'hf1, 8'h02);
    $display("test resets done");
    results();
  end
endmodule : testbench
`default_nettype wire
